/* fibc_pkg.sv */
// Constants and types shared by the flash reprogramming and banking control block
package fibc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] FIBC_IDX_ADDR_LOW  = 10'h0AC;
    localparam logic [9:0] FIBC_IDX_ADDR_HIGH = 10'h0AD;
    localparam logic [9:0] FIBC_IDX_BANK_CTRL = 10'h0AE;
    localparam logic [9:0] FIBC_IDX_DATA_BUF  = 10'h0AF;
    localparam logic [9:0] FIBC_IDX_COMMAND   = 10'h0B0;

    // Bus widths
    localparam int FIBC_PADDR_W = 12;

    // Bank control field positions and reset value
    localparam int         FIBC_BANK_EN_BIT  = 3;
    localparam int         FIBC_PIN_SEL_LSB  = 0;
    localparam logic [7:0] FIBC_BANK_CTRL_RST = 8'h07;

    // Command register field positions
    localparam int FIBC_CMD_MODE_LSB  = 0;
    localparam int FIBC_CMD_UPPER_BIT = 2;
    localparam int FIBC_CMD_LOADER_BIT = 3;
    localparam int FIBC_CMD_START_BIT = 7;

    // Reset values of the plain registers
    localparam logic [7:0] FIBC_ADDR_RST = 8'h00;
    localparam logic [7:0] FIBC_DATA_RST = 8'h00;
    localparam logic [7:0] FIBC_CMD_RST  = 8'h00;

    // Operation modes written into the command register
    typedef enum logic [1:0] {
        FIBC_MODE_READ    = 2'h0,
        FIBC_MODE_PROGRAM = 2'h1,
        FIBC_MODE_ERASE   = 2'h2,
        FIBC_MODE_RSVD    = 2'h3
    } fibc_mode_t;

    // Array operation codes
    localparam logic [3:0] FIBC_OP_READ    = 4'h0;
    localparam logic [3:0] FIBC_OP_PROGRAM = 4'h1;
    localparam logic [3:0] FIBC_OP_ERASE   = 4'h2;

    // Sequencer states
    typedef enum logic [1:0] {
        FIBC_ST_IDLE = 2'b01,
        FIBC_ST_BUSY = 2'b10
    } fibc_state_t;
endpackage

/* fibc_flash_isp_bank_control.sv */
// Flash reprogramming sequencer and code-fetch bank line, with APB registers
`timescale 1ns/1ps
`default_nettype none
module fibc_flash_isp_bank_control
    import fibc_pkg::*;
(
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    input  wire logic                              ce,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [fibc_pkg::FIBC_PADDR_W-1:0] paddr,
    input  wire logic [31:0]                       pwdata,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    input  wire logic [7:0]                        port1_pins,
    output logic                                   fetch_bank_line,
    output logic                                   array_chip_enable_n,
    output logic                                   array_output_enable_n,
    output logic      [3:0]                        array_op_code,
    output logic                                   app_bank_upper,
    output logic                                   loader_region_select,
    output logic      [15:0]                       array_addr,
    output logic      [7:0]                        array_wdata,
    input  wire logic [7:0]                        array_rdata,
    input  wire logic                              array_done
);
    import fibc_pkg::*;

    // Array operation code for a command mode
    function automatic logic [3:0] op_code_of(input logic [1:0] mode);
        case (mode)
            FIBC_MODE_PROGRAM: op_code_of = FIBC_OP_PROGRAM;
            FIBC_MODE_ERASE:   op_code_of = FIBC_OP_ERASE;
            default:           op_code_of = FIBC_OP_READ;
        endcase
    endfunction

    // Register decode by word index
    function automatic logic hit(input logic [FIBC_PADDR_W-1:0] a, input logic [9:0] idx);
        hit = (a[FIBC_PADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
    endfunction

    fibc_state_t state;
    fibc_state_t next_state;
    logic [7:0]  prog_addr_low;
    logic [7:0]  prog_addr_high;
    logic [7:0]  rom_bank_control;
    logic [7:0]  prog_data_byte;
    logic [7:0]  command;
    logic [7:0]  next_prog_addr_low;
    logic [7:0]  next_prog_addr_high;
    logic [7:0]  next_rom_bank_control;
    logic [7:0]  next_prog_data_byte;
    logic [7:0]  next_command;
    logic [31:0] next_prdata;
    logic        next_chip_en_n;
    logic        next_out_en_n;
    logic [3:0]  next_op_code;
    logic        next_bank_upper;
    logic        next_loader_sel;
    logic        next_fetch_line;
    logic [7:0]  pin_meta;
    logic [7:0]  pin_sync;
    logic        busy;
    logic        setup;
    logic        access;
    logic        mapped;
    logic        locked;
    logic        wr_ok;
    logic        start;
    logic        bank_span_enable;
    logic [2:0]  upper_line_pin_select;

    assign busy                  = (state == FIBC_ST_BUSY);
    assign setup                 = psel && !penable;
    assign access                = psel && penable && ce;
    assign bank_span_enable      = rom_bank_control[FIBC_BANK_EN_BIT];
    assign upper_line_pin_select = rom_bank_control[FIBC_PIN_SEL_LSB +: 3];
    assign array_addr            = {prog_addr_high, prog_addr_low};
    assign array_wdata           = prog_data_byte;

    // APB decode; ISP registers refuse writes while an operation runs
    always_comb begin
        mapped = hit(paddr, FIBC_IDX_ADDR_LOW) || hit(paddr, FIBC_IDX_ADDR_HIGH)
              || hit(paddr, FIBC_IDX_BANK_CTRL) || hit(paddr, FIBC_IDX_DATA_BUF)
              || hit(paddr, FIBC_IDX_COMMAND);
        locked = pwrite && busy && !hit(paddr, FIBC_IDX_BANK_CTRL);
        wr_ok  = access && pwrite && mapped && !locked;
        start  = wr_ok && hit(paddr, FIBC_IDX_COMMAND) && pwdata[FIBC_CMD_START_BIT]
              && (pwdata[FIBC_CMD_MODE_LSB +: 2] != FIBC_MODE_RSVD);
    end

    assign pready  = ce;
    assign pslverr = psel && penable && (!mapped || locked);

    // Register next values and read data
    always_comb begin
        next_prog_addr_low    = prog_addr_low;
        next_prog_addr_high   = prog_addr_high;
        next_rom_bank_control = rom_bank_control;
        next_prog_data_byte   = prog_data_byte;
        next_command          = command;
        next_prdata           = prdata;
        if (wr_ok) begin
            if (hit(paddr, FIBC_IDX_ADDR_LOW)) begin
                next_prog_addr_low = pwdata[7:0];
            end
            if (hit(paddr, FIBC_IDX_ADDR_HIGH)) begin
                next_prog_addr_high = pwdata[7:0];
            end
            if (hit(paddr, FIBC_IDX_BANK_CTRL)) begin
                next_rom_bank_control = {4'h0, pwdata[3:0]};  // Upper nibble reserved
            end
            if (hit(paddr, FIBC_IDX_DATA_BUF)) begin
                next_prog_data_byte = pwdata[7:0];
            end
            if (hit(paddr, FIBC_IDX_COMMAND)) begin
                next_command = {start, 3'h0, pwdata[3:0]};
            end
        end
        // Read result lands in the data buffer at completion
        if (busy && array_done) begin
            if (command[FIBC_CMD_MODE_LSB +: 2] == FIBC_MODE_READ) begin
                next_prog_data_byte = array_rdata;
            end
            next_command[FIBC_CMD_START_BIT] = 1'b0;
        end
        if (setup) begin
            next_prdata = 32'h0000_0000;
            if (hit(paddr, FIBC_IDX_ADDR_LOW)) begin
                next_prdata[7:0] = prog_addr_low;
            end
            if (hit(paddr, FIBC_IDX_ADDR_HIGH)) begin
                next_prdata[7:0] = prog_addr_high;
            end
            if (hit(paddr, FIBC_IDX_BANK_CTRL)) begin
                next_prdata[7:0] = rom_bank_control;
            end
            if (hit(paddr, FIBC_IDX_DATA_BUF)) begin
                next_prdata[7:0] = prog_data_byte;
            end
            if (hit(paddr, FIBC_IDX_COMMAND)) begin
                next_prdata[7:0] = {busy, command[6:0]};
            end
        end
    end

    // Sequencer and array control
    always_comb begin
        next_state      = state;
        next_chip_en_n  = array_chip_enable_n;
        next_out_en_n   = array_output_enable_n;
        next_op_code    = array_op_code;
        next_bank_upper = app_bank_upper;
        next_loader_sel = loader_region_select;
        case (state)
            FIBC_ST_IDLE: begin
                if (start) begin
                    next_state      = FIBC_ST_BUSY;
                    next_chip_en_n  = 1'b0;
                    next_out_en_n   = (pwdata[FIBC_CMD_MODE_LSB +: 2] != FIBC_MODE_READ);
                    next_op_code    = op_code_of(pwdata[FIBC_CMD_MODE_LSB +: 2]);
                    next_bank_upper = pwdata[FIBC_CMD_UPPER_BIT];
                    next_loader_sel = pwdata[FIBC_CMD_LOADER_BIT];
                end
            end
            FIBC_ST_BUSY: begin
                if (array_done) begin  // Everything held until the array reports done
                    next_state     = FIBC_ST_IDLE;
                    next_chip_en_n = 1'b1;
                    next_out_en_n  = 1'b1;
                end
            end
            default: begin
                next_state     = FIBC_ST_IDLE;
                next_chip_en_n = 1'b1;
                next_out_en_n  = 1'b1;
            end
        endcase
    end

    // Extra top fetch line from the selected port-1 pin
    always_comb begin
        next_fetch_line = bank_span_enable && pin_sync[upper_line_pin_select];
    end

    // State registers, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state                 <= FIBC_ST_IDLE;
            prog_addr_low         <= FIBC_ADDR_RST;
            prog_addr_high        <= FIBC_ADDR_RST;
            rom_bank_control      <= FIBC_BANK_CTRL_RST;  // Pin 7 selected
            prog_data_byte        <= FIBC_DATA_RST;
            command               <= FIBC_CMD_RST;
            prdata                <= 32'h0000_0000;
            array_chip_enable_n   <= 1'b1;
            array_output_enable_n <= 1'b1;
            array_op_code         <= FIBC_OP_READ;
            app_bank_upper        <= 1'b0;
            loader_region_select  <= 1'b0;
            fetch_bank_line       <= 1'b0;
            pin_meta              <= 8'h00;
            pin_sync              <= 8'h00;
        end else if (ce) begin
            state                 <= next_state;
            prog_addr_low         <= next_prog_addr_low;
            prog_addr_high        <= next_prog_addr_high;
            rom_bank_control      <= next_rom_bank_control;
            prog_data_byte        <= next_prog_data_byte;
            command               <= next_command;
            prdata                <= next_prdata;
            array_chip_enable_n   <= next_chip_en_n;
            array_output_enable_n <= next_out_en_n;
            array_op_code         <= next_op_code;
            app_bank_upper        <= next_bank_upper;
            loader_region_select  <= next_loader_sel;
            fetch_bank_line       <= next_fetch_line;
            pin_meta              <= port1_pins;
            pin_sync              <= pin_meta;
        end
    end

    // Checks on the array control and the bank line
    a_chip_enable_busy: assert property (@(posedge pclk) disable iff (!presetn)
        busy |-> !array_chip_enable_n)
        else $error("chip enable not asserted during operation");
    a_idle_chip_off: assert property (@(posedge pclk) disable iff (!presetn)
        !busy |-> array_chip_enable_n && array_output_enable_n)
        else $error("array enabled while idle");
    a_output_enable_read: assert property (@(posedge pclk) disable iff (!presetn)
        busy |-> (array_output_enable_n == (array_op_code != FIBC_OP_READ)))
        else $error("output enable does not match operation");
    a_op_code_start: assert property (@(posedge pclk) disable iff (!presetn)
        (start && ce && !busy) |=> busy && array_op_code == op_code_of($past(pwdata[1:0]))
            && app_bank_upper == $past(pwdata[2]) && loader_region_select == $past(pwdata[3]))
        else $error("wrong operation code or region on start");
    a_erase_code: assert property (@(posedge pclk) disable iff (!presetn)
        busy && command[1:0] == FIBC_MODE_ERASE |-> array_op_code == 4'h2)
        else $error("erase not coded as erase");
    a_hold_stable: assert property (@(posedge pclk) disable iff (!presetn)
        busy && $past(busy) |-> $stable(array_addr) && $stable(array_op_code)
            && $stable(app_bank_upper) && $stable(loader_region_select) && $stable(array_wdata))
        else $error("array inputs changed during operation");
    a_read_capture: assert property (@(posedge pclk) disable iff (!presetn)
        (busy && array_done && ce && array_op_code == FIBC_OP_READ) |=> !busy
            && prog_data_byte == $past(array_rdata))
        else $error("read byte not captured");
    a_bank_line: assert property (@(posedge pclk) disable iff (!presetn)
        ce |=> fetch_bank_line == ($past(bank_span_enable) && $past(pin_sync[upper_line_pin_select])))
        else $error("bank line does not follow selected pin");

    // Further checks on refusals, release after done and reserved fields
    a_done_release: assert property (@(posedge pclk) disable iff (!presetn)
        (busy && array_done && ce) |=> !busy && array_chip_enable_n && array_output_enable_n)
        else $error("array enables not released after done");
    a_refused_write: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && busy && !hit(paddr, FIBC_IDX_BANK_CTRL)) |-> pslverr)
        else $error("write during operation not refused");
    a_reserved_no_start: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ok && !busy && hit(paddr, FIBC_IDX_COMMAND) && pwdata[1:0] == FIBC_MODE_RSVD) |=> !busy)
        else $error("reserved mode started an operation");
    a_prdata_upper: assert property (@(posedge pclk) disable iff (!presetn)
        prdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_bank_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        rom_bank_control[7:4] == 4'h0)
        else $error("bank control reserved bits set");
    a_erase_outputs: assert property (@(posedge pclk) disable iff (!presetn)
        (busy && array_op_code == FIBC_OP_ERASE) |-> array_output_enable_n && !array_chip_enable_n)
        else $error("erase drives wrong enables");
    a_out_en_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (busy && $past(busy)) |-> $stable(array_output_enable_n) && $stable(array_chip_enable_n))
        else $error("array enables changed during operation");

    c_program: cover property (@(posedge pclk) disable iff (!presetn)
        busy && array_op_code == FIBC_OP_PROGRAM ##1 !busy);
    c_read_loader: cover property (@(posedge pclk) disable iff (!presetn)
        busy && loader_region_select && array_op_code == FIBC_OP_READ ##1 !busy);
    c_erase_upper: cover property (@(posedge pclk) disable iff (!presetn)
        busy && app_bank_upper && array_op_code == FIBC_OP_ERASE);
    c_bank_high: cover property (@(posedge pclk) disable iff (!presetn)
        fetch_bank_line);
    c_bank_low: cover property (@(posedge pclk) disable iff (!presetn)
        bank_span_enable && !fetch_bank_line);
endmodule
`default_nettype wire

/* fibc_flash_array_model.sv */
// Behavioural model of the embedded flash arrays behind the sequencer
`timescale 1ns/1ps
`default_nettype none
module fibc_flash_array_model #(
    parameter logic [7:0] ERASED_BYTE = 8'hFF
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        array_chip_enable_n,
    input  wire logic        array_output_enable_n,
    input  wire logic [3:0]  array_op_code,
    input  wire logic        app_bank_upper,
    input  wire logic        loader_region_select,
    input  wire logic [15:0] array_addr,
    input  wire logic [7:0]  array_wdata,
    input  wire logic [7:0]  lat,
    output logic      [7:0]  array_rdata,
    output logic             array_done,
    output logic             fault
);
    logic [7:0]  mem [3][int];
    logic        busy;
    logic        hold;
    logic [7:0]  rd_q;
    logic [31:0] snap;
    logic [31:0] now_v;
    int          cnt;
    int          rg;
    int          a;
    // Everything the array sees, compared cycle by cycle while busy
    assign now_v = {array_chip_enable_n, array_output_enable_n, array_op_code, app_bank_upper,
                    loader_region_select, array_addr, array_wdata};
    // Outside the done cycle the data lines show the inverse of the last byte
    assign array_rdata = array_done ? rd_q : ~rd_q;
    // One operation per chip enable, answered after lat extra cycles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy = 1'h0;
            hold = 1'h0;
            array_done <= 1'h0;
            fault <= 1'h0;
            rd_q <= ERASED_BYTE;
        end else begin
            array_done <= 1'h0;
            if (busy && now_v !== snap) fault <= 1'h1;
            rg = loader_region_select ? 2 : (app_bank_upper ? 1 : 0);
            a = loader_region_select ? int'(array_addr[11:0]) : int'(array_addr);
            if (!busy && !hold && array_chip_enable_n === 1'h0) begin
                busy = 1'h1;
                cnt = int'(lat);
                snap = now_v;
            end else if (busy && cnt > 0) begin
                cnt--;
            end else if (busy) begin
                // Program can only clear bits, as real flash does
                case (array_op_code)
                    4'h2: mem[rg].delete();
                    4'h1: mem[rg][a] = (mem[rg].exists(a) ? mem[rg][a] : ERASED_BYTE) & array_wdata;
                    default: rd_q <= mem[rg].exists(a) ? mem[rg][a] : ERASED_BYTE;
                endcase
                busy = 1'h0;
                hold = 1'h1;
                array_done <= 1'h1;
            end else if (hold && array_chip_enable_n === 1'h1) begin
                hold = 1'h0;
            end
        end
    end
endmodule
`default_nettype wire

/* test_fibc_flash_isp_bank_control.sv */
// Self-checking bench for the flash reprogramming and banking control block
`timescale 1ns/1ps
`default_nettype none
module test_fibc_flash_isp_bank_control;
    import fibc_pkg::*;
    typedef struct {logic [1:0] md; logic up; logic ld; logic [15:0] ad; logic [7:0] wd; logic [7:0] rd;
                    logic [7:0] lt;} fibc_row_t;
    localparam logic [11:0] ad_lo = {FIBC_IDX_ADDR_LOW, 2'h0};
    localparam logic [11:0] ad_hi = {FIBC_IDX_ADDR_HIGH, 2'h0};
    localparam logic [11:0] ad_bk = {FIBC_IDX_BANK_CTRL, 2'h0};
    localparam logic [11:0] ad_db = {FIBC_IDX_DATA_BUF, 2'h0};
    localparam logic [11:0] ad_cm = {FIBC_IDX_COMMAND, 2'h0};
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, fetch_bank_line, er, fault;
    logic array_chip_enable_n, array_output_enable_n, app_bank_upper, loader_region_select, array_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  port1_pins, array_wdata, array_rdata, lat;
    logic [3:0]  array_op_code;
    logic [15:0] array_addr;
    fibc_row_t   rows [12];
    int          err_count, n_checks, cyc, k, i;
    fibc_flash_isp_bank_control i_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .port1_pins, .fetch_bank_line, .array_chip_enable_n,
        .array_output_enable_n, .array_op_code, .app_bank_upper, .loader_region_select, .array_addr,
        .array_wdata, .array_rdata, .array_done);
    fibc_flash_array_model i_array (.pclk, .presetn, .array_chip_enable_n, .array_output_enable_n,
        .array_op_code, .app_bank_upper, .loader_region_select, .array_addr, .array_wdata, .lat,
        .array_rdata, .array_done, .fault);
    // Clock at 25 MHz
    initial begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end
    // Cut a hang short
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
            err_count++;
        end
    endtask
    // One APB transfer; read data and error taken at the completing edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wait_ce(input logic lvl);
        for (k = 0; k < 60 && array_chip_enable_n !== lvl; k++) @(posedge pclk);
    endtask
    // Load address, data and command, then watch the array side
    task automatic run_op(input fibc_row_t r);
        lat <= r.lt;
        apb(1'h1, ad_lo, {24'h0, r.ad[7:0]});
        apb(1'h1, ad_hi, {24'h0, r.ad[15:8]});
        apb(1'h1, ad_db, {24'h0, r.wd});
        apb(1'h1, ad_cm, {24'h0, 1'h1, 3'h0, r.ld, r.up, r.md});
        wait_ce(1'h0);
        chk("chip_enable_n", 32'h0, array_chip_enable_n);
        chk("output_enable_n", {31'h0, r.md != 2'h0}, array_output_enable_n);
        chk("op_code", (r.md == 2'h2) ? 32'h2 : (r.md == 2'h1) ? 32'h1 : 32'h0, array_op_code);
        chk("bank_upper", {31'h0, r.up}, app_bank_upper);
        chk("loader_sel", {31'h0, r.ld}, loader_region_select);
        chk("array_addr", {16'h0, r.ad}, array_addr);
        chk("array_wdata", {24'h0, r.wd}, array_wdata);
        wait_ce(1'h1);
        chk("output_enable_n_end", 32'h1, array_output_enable_n);
        apb(1'h0, ad_cm, 32'h0);
        chk("command_idle", {28'h0, r.ld, r.up, r.md}, rd);
        apb(1'h0, ad_db, 32'h0);
        if (r.md == 2'h0) chk("read_byte", {24'h0, r.rd}, rd);
    endtask
    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, port1_pins, lat} = '0;
        ce = 1'h1;
        rows = '{'{2'h2, 1'h0, 1'h0, 16'h0000, 8'h00, 8'h00, 8'h0}, '{2'h1, 1'h0, 1'h0, 16'h1234, 8'h5A, 8'h00, 8'h1},
                 '{2'h1, 1'h1, 1'h0, 16'hFFFF, 8'hA5, 8'h00, 8'h2}, '{2'h1, 1'h0, 1'h1, 16'h0FFF, 8'h3C, 8'h00, 8'h0},
                 '{2'h0, 1'h0, 1'h0, 16'h1234, 8'h00, 8'h5A, 8'h3}, '{2'h0, 1'h1, 1'h0, 16'hFFFF, 8'h00, 8'hA5, 8'h0},
                 '{2'h0, 1'h0, 1'h1, 16'h0FFF, 8'h00, 8'h3C, 8'h1}, '{2'h2, 1'h1, 1'h0, 16'h0000, 8'h00, 8'h00, 8'h4},
                 '{2'h0, 1'h1, 1'h0, 16'hFFFF, 8'h00, 8'hFF, 8'h0}, '{2'h2, 1'h0, 1'h1, 16'h0000, 8'h00, 8'h00, 8'h2},
                 '{2'h0, 1'h0, 1'h1, 16'h0FFF, 8'h00, 8'hFF, 8'h0}, '{2'h0, 1'h0, 1'h0, 16'h1234, 8'h00, 8'h5A, 8'h5}};
        repeat (2) @(posedge pclk);
        chk("reset_chip_enable_n", 32'h1, array_chip_enable_n);
        chk("reset_bank_line", 32'h0, fetch_bank_line);
        presetn <= 1'h1;
        apb(1'h0, ad_bk, 32'h0);
        chk("bank_ctrl_reset", {24'h0, FIBC_BANK_CTRL_RST}, rd);
        apb(1'h0, ad_cm, 32'h0);
        chk("command_reset", {24'h0, FIBC_CMD_RST}, rd);
        $display("test reset done");
        for (i = 0; i < 12; i++) run_op(rows[i]);
        $display("test operation table done");
        // Writes to the sequencer registers are refused while an operation runs
        run_op('{2'h1, 1'h0, 1'h0, 16'h00C3, 8'hF0, 8'h00, 8'h0});
        lat <= 8'd30;
        apb(1'h1, ad_cm, 32'h81);
        wait_ce(1'h0);
        apb(1'h1, ad_lo, 32'h55);
        chk("busy_write_error", 32'h1, er);
        apb(1'h0, ad_lo, 32'h0);
        chk("busy_write_ignored", 32'hC3, rd);
        chk("addr_held", 32'h00C3, array_addr);
        wait_ce(1'h1);
        // Reserved mode and unmapped address
        apb(1'h1, ad_cm, 32'h83);
        repeat (3) @(posedge pclk);
        chk("reserved_no_start", 32'h1, array_chip_enable_n);
        apb(1'h0, ad_cm, 32'h0);
        chk("reserved_command", 32'h03, rd);
        apb(1'h0, 12'h000, 32'h0);
        chk("unmapped_error", 32'h1, er);
        chk("unmapped_data", 32'h0, rd);
        $display("test refusals done");
        // Each pin select drives the fetch bank line from its own pin
        for (i = 0; i < 8; i++) begin
            apb(1'h1, ad_bk, 32'h8 | i);
            port1_pins <= 8'h01 << i;
            repeat (4) @(posedge pclk);
            chk("bank_line_high", 32'h1, fetch_bank_line);
            port1_pins <= ~(8'h01 << i);
            repeat (4) @(posedge pclk);
            chk("bank_line_low", 32'h0, fetch_bank_line);
        end
        apb(1'h1, ad_bk, 32'h7);
        port1_pins <= 8'hFF;
        repeat (4) @(posedge pclk);
        chk("bank_line_disabled", 32'h0, fetch_bank_line);
        ce <= 1'h0;
        repeat (2) @(posedge pclk);
        chk("pready_frozen", 32'h0, pready);
        ce <= 1'h1;
        chk("array_outputs_stable", 32'h0, fault);
        $display("test banking done");
        end_of_test();
    end
endmodule
`default_nettype wire
